// ---- hdl/bsm_ms_timer.sv ----
// file: millisecond down-counter driven by a shared tick
`timescale 1ns/100ps
module bsm_ms_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] count,
    // status
    output logic done
);

    logic [W-1:0] cnt_q;

    // restart on load, count tick-wise toward zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count; // R21
        end else if (tick && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == '0) && !load;

endmodule

// ---- hdl/bsm_pkg.sv ----
// package: constants, register map and types for the brake and standstill monitor
// Operation
// R1 - contouring error response class 0..3 selectable, class 0 warning, reset 3
// R2 - software should avoid class 0: motor may move unbraked
// R3 - brake request rises once amplifier enabled and holding torque present
// R4 - brake request high means release/released, low means apply/applied
// R5 - release delay 0..200 ms, default 0; brake open after delay
// R6 - on disable request drops low, controller stays active for delay
// R7 - apply delay 0..100 ms, default 0, control kept with brake applied
// R8 - voltage reduction selector: 1 enables reduction, 0 disables
// R9 - with reduction, full drive 100 ms after release then holding level
// R10 - power-on resets brake control, button, no brake voltage, led off
// R11 - indicator led blinks on brake output overload or short circuit
// R12 - standstill reported after deviation stays in window for dwell time
// R13 - window width 16-bit increments, range 0..32767, default 10
// R14 - dwell time 16-bit milliseconds, range 0..32767, default 1
// R15 - selector 6 drives active-low function output for in-window deviation
// R16 - selector codes 1..6 choose message, 0 reserved, default 5
// R17 - window evaluated only in electronic gear or position control mode
// R18 - status bit 6 set while deviation lies in standstill window
// R19 - brake released while local push-button is pressed; the code does not release while brake_fault is high
// R20 - function output held at least two seconds after a message
// R21 - delays measured with a one-millisecond tick counter from sys_clk
package bsm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int BOOST_MS = 100;
    localparam int HOLD_MSG_MS = 2000;
    localparam int BLINK_MS = 250;

    // ------------------------------------------------------------
    // register map (word indices)
    // ------------------------------------------------------------
    localparam logic [3:0] A_RESP = 4'h0;
    localparam logic [3:0] A_REL = 4'h1;
    localparam logic [3:0] A_APP = 4'h2;
    localparam logic [3:0] A_WIN = 4'h3;
    localparam logic [3:0] A_DWELL = 4'h4;
    localparam logic [3:0] A_FSEL = 4'h5;
    localparam logic [3:0] A_STAT = 4'h6;
    localparam logic [3:0] A_BCTL = 4'h7;

    localparam logic [15:0] RST_RESP = 16'h0003;
    localparam logic [15:0] RST_REL = 16'h0000;
    localparam logic [15:0] RST_APP = 16'h0000;
    localparam logic [15:0] RST_WIN = 16'h000A;
    localparam logic [15:0] RST_DWELL = 16'h0001;
    localparam logic [15:0] RST_FSEL = 16'h0005;
    localparam logic [15:0] RST_BCTL = 16'h0000;

    localparam logic [15:0] MAX_REL = 16'h00C8;
    localparam logic [15:0] MAX_APP = 16'h0064;
    localparam logic [15:0] MAX_WIN = 16'h7FFF;
    localparam logic [15:0] MAX_CLS = 16'h0003;
    localparam logic [15:0] MAX_FSEL = 16'h0006;

    // status and control bit positions
    localparam int ST_INWIN = 6;
    localparam int ST_STILL = 7;
    localparam int ST_BOPEN = 8;
    localparam int ST_CTRL = 9;
    localparam int BC_REDUCE = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FS_RSVD = 3'h0,
        FS_TEMP = 3'h1,
        FS_I2T = 3'h2,
        FS_FOLLOW = 3'h3,
        FS_OVLD = 3'h4,
        FS_STILL = 3'h5,
        FS_INWIN = 3'h6
    } bsm_fsel_t;

    typedef enum logic [1:0] {
        BK_OFF = 2'h0,
        BK_REL = 2'h1,
        BK_ON = 2'h2,
        BK_APP = 2'h3
    } bsm_bk_t;

    typedef struct packed {
        logic amp_enable;
        logic holding_torque;
        logic gear_mode;
        logic pos_mode;
    } bsm_drive_t;

    typedef struct packed {
        logic overtemp;
        logic i2t_limit;
        logic contour_error;
    } bsm_msg_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bsm_bus_t;

endpackage

// ---- hdl/bsm_tick.sv ----
// file: one-millisecond tick generator
`timescale 1ns/100ps
module bsm_tick #(
    parameter int CYC = bsm_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // tick out
    output logic tick
);

    logic [31:0] div_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_q <= '0;
            tick <= 1'b0;
        end else if (div_q == 32'(CYC - 1)) begin
            div_q <= '0;
            tick <= 1'b1; // R21
        end else begin
            div_q <= div_q + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule

// ---- hdl/bsm_top.sv ----
// file: brake sequencing and standstill monitor top level
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module bsm_top #(
    parameter int TICK_CYC = bsm_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire bsm_pkg::bsm_bus_t bus,
    output logic [15:0] rdata,
    // drive state
    input wire bsm_pkg::bsm_drive_t drive,
    input wire bsm_pkg::bsm_msg_t msg,
    input wire logic [15:0] deviation,
    // brake controller side
    input wire logic brake_button,
    input wire logic brake_fault,
    // outputs
    output logic brake_release_request,
    output logic controller_active,
    output logic brake_drive_full,
    output logic brake_drive_hold,
    output logic brake_led,
    output logic function_output_n,
    output logic contour_error_stop,
    output logic [1:0] contour_error_response
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] resp_q;
    logic [15:0] rel_q;
    logic [15:0] app_q;
    logic [15:0] win_q;
    logic [15:0] dwell_q;
    logic [15:0] fsel_q;
    logic [15:0] bctl_q;
    logic [15:0] stat_q;
    logic tick;

    bsm_tick #(
        .CYC(TICK_CYC)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    // out-of-range writes are dropped, registers keep their value; bctl takes bit 0 of every write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resp_q <= bsm_pkg::RST_RESP; // R1
            rel_q <= bsm_pkg::RST_REL; // R5
            app_q <= bsm_pkg::RST_APP; // R7
            win_q <= bsm_pkg::RST_WIN; // R13
            dwell_q <= bsm_pkg::RST_DWELL; // R14
            fsel_q <= bsm_pkg::RST_FSEL; // R16
            bctl_q <= bsm_pkg::RST_BCTL;
        end else if (bus.wr) begin
            case (bus.addr)
                bsm_pkg::A_RESP: begin
                    if (bus.wdata <= bsm_pkg::MAX_CLS) begin
                        resp_q <= bus.wdata; // R1
                    end
                end
                bsm_pkg::A_REL: begin
                    if (bus.wdata <= bsm_pkg::MAX_REL) begin
                        rel_q <= bus.wdata; // R5
                    end
                end
                bsm_pkg::A_APP: begin
                    if (bus.wdata <= bsm_pkg::MAX_APP) begin
                        app_q <= bus.wdata; // R7
                    end
                end
                bsm_pkg::A_WIN: begin
                    if (bus.wdata <= bsm_pkg::MAX_WIN) begin
                        win_q <= bus.wdata; // R13
                    end
                end
                bsm_pkg::A_DWELL: begin
                    if (bus.wdata <= bsm_pkg::MAX_WIN) begin
                        dwell_q <= bus.wdata; // R14
                    end
                end
                bsm_pkg::A_FSEL: begin
                    if (bus.wdata >= 16'h0001 &&
                        bus.wdata <= bsm_pkg::MAX_FSEL) begin
                        fsel_q <= bus.wdata; // R16
                    end
                end
                bsm_pkg::A_BCTL: begin
                    bctl_q <= {15'h0000, bus.wdata[bsm_pkg::BC_REDUCE]};
                end
                default: begin
                end
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr)
                bsm_pkg::A_RESP: rdata <= resp_q;
                bsm_pkg::A_REL: rdata <= rel_q;
                bsm_pkg::A_APP: rdata <= app_q;
                bsm_pkg::A_WIN: rdata <= win_q;
                bsm_pkg::A_DWELL: rdata <= dwell_q;
                bsm_pkg::A_FSEL: rdata <= fsel_q;
                bsm_pkg::A_STAT: rdata <= stat_q;
                bsm_pkg::A_BCTL: rdata <= bctl_q;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // contouring error response
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            contour_error_response <= bsm_pkg::RST_RESP[1:0];
            contour_error_stop <= 1'b0;
        end else begin
            contour_error_response <= resp_q[1:0]; // R1
            // class 0 is warning only; software should avoid it
            contour_error_stop <= msg.contour_error &&
                                  (resp_q[1:0] != 2'h0); // R1 R2
        end
    end

    // ------------------------------------------------------------
    // brake sequencing
    // ------------------------------------------------------------
    bsm_pkg::bsm_bk_t bk_q;
    logic want_on;
    logic bk_load;
    logic [15:0] bk_cnt;
    logic bk_done;

    assign want_on = drive.amp_enable && drive.holding_torque;
    assign bk_load = (bk_q == bsm_pkg::BK_OFF && want_on) ||
                     ((bk_q == bsm_pkg::BK_REL ||
                       bk_q == bsm_pkg::BK_ON) && !drive.amp_enable);
    assign bk_cnt = (bk_q == bsm_pkg::BK_OFF) ? rel_q : app_q;

    bsm_ms_timer #(
        .W(16)
    ) u_bk_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .load(bk_load),
        .count(bk_cnt),
        .done(bk_done)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bk_q <= bsm_pkg::BK_OFF; // R10
        end else begin
            case (bk_q)
                bsm_pkg::BK_OFF: begin
                    if (want_on) begin
                        bk_q <= bsm_pkg::BK_REL; // R3
                    end
                end
                bsm_pkg::BK_REL: begin
                    if (!drive.amp_enable) begin
                        bk_q <= bsm_pkg::BK_APP; // R6
                    end else if (bk_done) begin
                        bk_q <= bsm_pkg::BK_ON; // R5
                    end
                end
                bsm_pkg::BK_ON: begin
                    if (!drive.amp_enable) begin
                        bk_q <= bsm_pkg::BK_APP; // R6
                    end
                end
                bsm_pkg::BK_APP: begin
                    if (bk_done) begin
                        bk_q <= bsm_pkg::BK_OFF; // R7
                    end
                end
                default: bk_q <= bsm_pkg::BK_OFF;
            endcase
        end
    end

    // request high = release, low = apply
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            brake_release_request <= 1'b0;
            controller_active <= 1'b0;
        end else begin
            brake_release_request <= (bk_q == bsm_pkg::BK_REL) ||
                                     (bk_q == bsm_pkg::BK_ON); // R4
            controller_active <= (bk_q != bsm_pkg::BK_OFF); // R6 R7
        end
    end

    // ------------------------------------------------------------
    // brake controller drive stage
    // ------------------------------------------------------------
    logic rel_cmd;
    logic rel_cmd_q;
    logic boost_q;
    logic [15:0] boost_ms_q;
    logic [15:0] blink_q;
    logic led_q;

    assign rel_cmd = (brake_release_request || brake_button) &&
                     !brake_fault; // R19

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rel_cmd_q <= 1'b0; // R10
            boost_q <= 1'b0;
            boost_ms_q <= 16'h0000;
        end else begin
            rel_cmd_q <= rel_cmd;
            if (rel_cmd && !rel_cmd_q) begin
                boost_q <= 1'b1; // R9
                boost_ms_q <= 16'(bsm_pkg::BOOST_MS);
            end else if (!rel_cmd) begin
                boost_q <= 1'b0;
            end else if (tick && boost_ms_q != 16'h0000) begin
                boost_ms_q <= boost_ms_q - 16'h0001;
                if (boost_ms_q == 16'h0001) begin
                    boost_q <= 1'b0; // R9
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            brake_drive_full <= 1'b0; // R10
            brake_drive_hold <= 1'b0;
        end else begin
            brake_drive_full <= rel_cmd && (boost_q || !rel_cmd_q ||
                !bctl_q[bsm_pkg::BC_REDUCE]); // R8 R9
            brake_drive_hold <= rel_cmd && rel_cmd_q && !boost_q &&
                bctl_q[bsm_pkg::BC_REDUCE]; // R8 R9
        end
    end

    // fault blink
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            blink_q <= 16'h0000;
            led_q <= 1'b0; // R10
            brake_led <= 1'b0;
        end else begin
            if (!brake_fault) begin
                blink_q <= 16'h0000;
                led_q <= 1'b0;
            end else if (tick) begin
                if (blink_q == 16'(bsm_pkg::BLINK_MS - 1)) begin
                    blink_q <= 16'h0000;
                    led_q <= !led_q; // R11
                end else begin
                    blink_q <= blink_q + 16'h0001;
                end
            end
            brake_led <= brake_fault && !led_q; // R11
        end
    end

    // ------------------------------------------------------------
    // standstill window
    // ------------------------------------------------------------
    logic [15:0] dev_abs;
    logic in_win;
    logic in_win_q;
    logic still_done;

    assign dev_abs = deviation[15] ? 16'(-deviation) : deviation;
    assign in_win = (drive.gear_mode || drive.pos_mode) &&
                    (dev_abs <= win_q); // R17

    bsm_ms_timer #(
        .W(16)
    ) u_still_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .load(in_win && !in_win_q),
        .count(dwell_q),
        .done(still_done)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_win_q <= 1'b0;
            stat_q <= 16'h0000;
        end else begin
            in_win_q <= in_win;
            stat_q <= 16'h0000;
            stat_q[bsm_pkg::ST_INWIN] <= in_win; // R18
            stat_q[bsm_pkg::ST_STILL] <= in_win && in_win_q &&
                                         still_done; // R12
            stat_q[bsm_pkg::ST_BOPEN] <= (bk_q == bsm_pkg::BK_ON);
            stat_q[bsm_pkg::ST_CTRL] <= (bk_q != bsm_pkg::BK_OFF);
        end
    end

    // ------------------------------------------------------------
    // function output
    // ------------------------------------------------------------
    logic msg_now;
    logic [15:0] hold_q;

    always_comb begin
        case (bsm_pkg::bsm_fsel_t'(fsel_q[2:0]))
            bsm_pkg::FS_TEMP: msg_now = msg.overtemp;
            bsm_pkg::FS_I2T: msg_now = msg.i2t_limit;
            bsm_pkg::FS_FOLLOW: msg_now = msg.contour_error;
            bsm_pkg::FS_OVLD: msg_now = msg.overtemp || msg.i2t_limit ||
                                        msg.contour_error;
            bsm_pkg::FS_STILL: msg_now = stat_q[bsm_pkg::ST_STILL];
            bsm_pkg::FS_INWIN: msg_now = stat_q[bsm_pkg::ST_INWIN]; // R15
            default: msg_now = 1'b0;
        endcase
    end

    // stretch each message to at least two seconds
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_q <= 16'h0000;
            function_output_n <= 1'b1;
        end else begin
            if (msg_now) begin
                hold_q <= 16'(bsm_pkg::HOLD_MSG_MS); // R20
            end else if (tick && hold_q != 16'h0000) begin
                hold_q <= hold_q - 16'h0001;
            end
            function_output_n <= !(msg_now || hold_q != 16'h0000); // R15
        end
    end

endmodule

// ---- verif/bsm_brake_amp.sv ----
// model: brake amplifier accessory with push-button and load fault
`timescale 1ns/100ps
module bsm_brake_amp (
    // clock
    input wire logic sys_clk,
    // from the block
    input wire logic brake_drive_full,
    input wire logic brake_drive_hold,
    // scenario commands
    input wire logic press_cmd,
    input wire logic short_cmd,
    // to the block; brake_open goes to the testbench
    output logic brake_button,
    output logic brake_fault,
    output logic brake_open
);
    always_ff @(posedge sys_clk) begin
        brake_button <= press_cmd;
        brake_fault <= short_cmd;
        brake_open <= brake_drive_full || brake_drive_hold;
    end
endmodule

// ---- verif/bsm_top_monitor.sv ----
// checker: port assertions for the brake and standstill monitor
`timescale 1ns/100ps
module bsm_top_monitor #(
    parameter int TICK_CYC = bsm_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire bsm_pkg::bsm_bus_t bus,
    input wire logic [15:0] rdata,
    // drive state
    input wire bsm_pkg::bsm_drive_t drive,
    input wire bsm_pkg::bsm_msg_t msg,
    // brake controller side
    input wire logic brake_fault,
    // outputs
    input wire logic brake_release_request,
    input wire logic brake_drive_full,
    input wire logic brake_drive_hold,
    input wire logic brake_led,
    input wire logic function_output_n,
    input wire logic contour_error_stop,
    input wire logic [1:0] contour_error_response
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // cycles the message output has been low
    logic [31:0] low_q;
    always_ff @(posedge sys_clk) begin
        if (rst || function_output_n) begin
            low_q <= 32'h0;
        end else if (low_q != 32'hFFFFFFFF) begin
            low_q <= low_q + 32'h1;
        end
    end

    sequence s_on;
        (drive.amp_enable && drive.holding_torque)[*2];
    endsequence
    sequence s_off;
        (!drive.amp_enable)[*2];
    endsequence

    property p_req_on;
        s_on |=> brake_release_request;
    endproperty
    property p_req_off;
        s_off |=> !brake_release_request;
    endproperty
    property p_rd_idle;
        !$past(bus.rd) |-> rdata == 16'h0000;
    endproperty
    property p_cls_zero;
        contour_error_stop |-> contour_error_response != 2'h0;
    endproperty
    property p_cls_stop;
        (msg.contour_error && contour_error_response != 2'h0)[*3]
            |-> contour_error_stop;
    endproperty
    property p_led_off;
        (!brake_fault)[*3] |-> !brake_led;
    endproperty
    property p_drive_excl;
        !(brake_drive_full && brake_drive_hold);
    endproperty
    property p_reset;
        $past(rst) |-> !brake_drive_full && !brake_drive_hold &&
            !brake_led && !brake_release_request && function_output_n;
    endproperty
    property p_fout_hold;
        $rose(function_output_n)
            |-> low_q >= (bsm_pkg::HOLD_MSG_MS - 1) * TICK_CYC;
    endproperty

    a_req_on: assert property (p_req_on)
        else $error("request did not rise after enable");
    a_req_off: assert property (p_req_off)
        else $error("request did not fall after disable");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    a_cls_zero: assert property (p_cls_zero)
        else $error("stop raised in warning class");
    a_cls_stop: assert property (p_cls_stop)
        else $error("no stop for contour error");
    a_led_off: assert property (p_led_off)
        else $error("led lit without fault");
    a_drive_excl: assert property (p_drive_excl)
        else $error("full and hold drive together");
    a_reset: assert property (p_reset)
        else $error("outputs not idle after reset");
    a_fout_hold: assert property (p_fout_hold)
        else $error("message output released too early");
endmodule

bind bsm_top bsm_top_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
    .sys_clk, .rst, .bus, .rdata, .drive, .msg, .brake_fault,
    .brake_release_request, .brake_drive_full, .brake_drive_hold,
    .brake_led, .function_output_n, .contour_error_stop,
    .contour_error_response
);

// ---- verif/bsm_top_test.sv ----
// testbench: registers, brake sequence, standstill and messages
`timescale 1ns/100ps
module bsm_top_test;
    localparam int TICK = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    bsm_pkg::bsm_bus_t bus = '0;
    bsm_pkg::bsm_drive_t drive = '0;
    bsm_pkg::bsm_msg_t msg = '0;
    logic [15:0] deviation = 16'h0000;
    logic press_cmd = 1'b0;
    logic short_cmd = 1'b0;
    logic brake_button, brake_fault, brake_open, req, ctrl, full, hold;
    logic led, fout_n, stop, led_d;
    logic [1:0] cls;
    logic [15:0] rdata, got, v;
    logic [3:0] a;
    logic [31:0] seed = 32'h1D4E002A;
    logic [15:0] sh [6] = '{16'h0003, 16'h0000, 16'h0000, 16'h000A,
                            16'h0001, 16'h0005};
    logic [19:0] corner [8] = '{20'h100C8, 20'h100C9, 20'h20065,
        20'h00004, 20'h50000, 20'h50007, 20'h38000, 20'h6FFFF};
    int bad_count = 0;
    int checked = 0;
    int flips;

    always #2.5 sys_clk = ~sys_clk;

    bsm_top #(.TICK_CYC(TICK)) u_dut (.sys_clk, .rst, .bus, .rdata,
        .drive, .msg, .deviation, .brake_button, .brake_fault,
        .brake_release_request(req), .controller_active(ctrl),
        .brake_drive_full(full), .brake_drive_hold(hold),
        .brake_led(led), .function_output_n(fout_n),
        .contour_error_stop(stop), .contour_error_response(cls));
    bsm_brake_amp u_amp (.sys_clk, .brake_drive_full(full),
        .brake_drive_hold(hold), .press_cmd, .short_cmd, .brake_button,
        .brake_fault, .brake_open);

    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] legal(input logic [3:0] ad,
                                          input logic [15:0] nv, old);
        logic [15:0] mx;
        mx = (ad == 4'h0) ? bsm_pkg::MAX_CLS : (ad == 4'h1) ?
            bsm_pkg::MAX_REL : (ad == 4'h2) ? bsm_pkg::MAX_APP :
            (ad == 4'h5) ? bsm_pkg::MAX_FSEL : bsm_pkg::MAX_WIN;
        if (nv > mx || (ad == 4'h5 && nv == 16'h0000)) begin
            return old;
        end
        return nv;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge sys_clk);
        bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge sys_clk);
        bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(posedge sys_clk);
        got = rdata;
    endtask
    task automatic wait_ms(input int n);
        repeat (n * TICK) @(posedge sys_clk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end

    // ----
    // scenarios
    // ----
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i));
            chk("reg", got, i < 6 ? sh[i] : 16'h0000);
        end
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            a = (i < 8) ? corner[i][19:16] : 4'(seed[15:0] % 16'h0006);
            v = (i < 8) ? corner[i][15:0] : seed[31:16] % 16'h0104;
            wr(a, v);
            if (a < 4'h6) begin
                sh[a] = legal(a, v, sh[a]);
            end
            rd(a);
            chk("rw", got, a < 4'h6 ? sh[a] : 16'h0000);
        end
        wr(bsm_pkg::A_REL, 16'h0003);
        wr(bsm_pkg::A_APP, 16'h0002);
        wr(bsm_pkg::A_BCTL, 16'h0000);
        drive <= 4'b1100;
        repeat (3) @(posedge sys_clk);
        chk("req", 16'(req), 16'h0001);
        wait_ms(1);
        rd(bsm_pkg::A_STAT);
        chk("open", 16'(got[8]), 16'h0000);
        wait_ms(110);
        rd(bsm_pkg::A_STAT);
        chk("open", 16'(got[8]), 16'h0001);
        chk("full", {14'h0, full, hold}, 16'h0002);
        drive <= 4'b0100;
        repeat (3) @(posedge sys_clk);
        chk("req", 16'(req), 16'h0000);
        chk("ctrl", 16'(ctrl), 16'h0001);
        wait_ms(4);
        chk("ctrl", 16'(ctrl), 16'h0000);
        wr(bsm_pkg::A_REL, 16'h0000);
        wr(bsm_pkg::A_BCTL, 16'h0001);
        drive <= 4'b1100;
        wait_ms(50);
        chk("boost", {14'h0, full, hold}, 16'h0002);
        wait_ms(60);
        chk("boost", {14'h0, full, hold}, 16'h0001);
        drive <= 4'b0000;
        wait_ms(5);
        chk("off", {14'h0, full, hold}, 16'h0000);
        press_cmd <= 1'b1;
        wait_ms(1);
        chk("button", 16'(brake_open), 16'h0001);
        press_cmd <= 1'b0;
        short_cmd <= 1'b1;
        flips = 0;
        for (int i = 0; i < 600 * TICK; i++) begin
            led_d = led;
            @(posedge sys_clk);
            flips += (led !== led_d) ? 1 : 0;
        end
        chk("blink", 16'(flips > 1), 16'h0001);
        short_cmd <= 1'b0;
        wait_ms(1);
        chk("led", 16'(led), 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(bsm_pkg::A_RESP, 16'(c));
            msg.contour_error <= 1'b1;
            wait_ms(1);
            chk("class", 16'(cls), 16'(c));
            chk("stop", 16'(stop), 16'(c != 0));
        end
        msg <= '0;
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wr(bsm_pkg::A_DWELL, 16'h0006);
        deviation <= 16'h0009;
        wait_ms(8);
        rd(bsm_pkg::A_STAT);
        chk("mode", {14'h0, got[7:6]}, 16'h0000);
        drive <= 4'b0010;
        wait_ms(4);
        deviation <= 16'h000B;
        wait_ms(1);
        rd(bsm_pkg::A_STAT);
        chk("out", 16'(got[6]), 16'h0000);
        deviation <= 16'h0009;
        wait_ms(3);
        rd(bsm_pkg::A_STAT);
        chk("dwell", {14'h0, got[7:6]}, 16'h0001);
        wait_ms(5);
        rd(bsm_pkg::A_STAT);
        chk("still", {14'h0, got[7:6]}, 16'h0003);
        chk("fout", 16'(fout_n), 16'h0000);
        deviation <= 16'h000B;
        wait_ms(1500);
        chk("fout", 16'(fout_n), 16'h0000);
        wait_ms(600);
        chk("fout", 16'(fout_n), 16'h0001);
        wr(bsm_pkg::A_FSEL, 16'h0006);
        drive <= 4'b0001;
        deviation <= 16'hFFF7;
        wait_ms(1);
        chk("inwin", 16'(fout_n), 16'h0000);
        stop_test();
    end
endmodule
